// ===== dlem_top.sv
/*
 dlem_top: line link supervisor with error monitor, configuration
 registers behind APB and line error counters. Assumes the line
 transceiver reports link-up and error events on pins, and applies
 the configuration outputs whenever line_restart_out pulses.
*/
// Summary of operation
// - after startup delay count errors per interval, judge against threshold
// - interval with errors >= threshold is errored; enough errored restarts
// - wait startup delay seconds after link comes up before inspecting
// - stop monitoring after the configured total intervals are inspected
// - threshold zero keeps the monitor disabled, no error restarts
// - total interval count zero runs the monitor forever
// - rate, clock, annex, probe, monitor settings apply at next restart
// - start command restarts the link and applies pending settings
// - timeslots 1 to 72 accepted, rate is timeslots times 64k
// - disabled port never establishes a link
// - internal mode: oscillator clocks line and serial sides
// - external mode: serial transmit clock drives line transmit
// - recover mode: line receive clock drives line tx and serial rx
// - loopback off, local analog, remote digital; prbs off, 511, prbs_with_errors
// - front panel switches start tests only when enabled
// - clear command zeroes all line error counters
// - settings are volatile; reset also clears the saved copy that recall restores
// - counters for crc, sync loss, fifo full, empty, slip, stuff
`timescale 1ns/1ps
module dlem_top #(
   parameter int SEC_CYCLES = dlem_pkg::SEC_CYCLES
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        line_link_up_in,
   input  wire logic [8:0]  line_err_evt_in,
   input  wire logic        fp_local_loop_in,
   input  wire logic        fp_remote_loop_in,
   output logic             line_enable_out,
   output logic             line_restart_out,
   output logic      [6:0]  rate_ts_out,
   output logic      [12:0] rate_kbps_out,
   output logic      [1:0]  line_tx_clk_sel_out,
   output logic      [1:0]  ser_clk_sel_out,
   output logic             annex_b_out,
   output logic             line_probe_out,
   output logic      [1:0]  loopback_out,
   output logic      [1:0]  prbs_out
);
   localparam int NPIN = dlem_pkg::ERR_NUM + 3;

   logic [NPIN-1:0] pin_s;
   logic [8:0]      evt_s;
   logic [8:0]      evt_prev_q;
   logic [8:0]      evt_pulse;
   logic            link_up_s;
   logic            fp_lal_s;
   logic            fp_rdl_s;
   logic [15:0]     err_cnt [dlem_pkg::ERR_NUM];

   // pins cross into the clock domain before anything reads them
   dlem_sync2 #(
      .WIDTH(NPIN)
   ) u_sync (
      .ref_clk_in(ref_clk_in),
      .rstn_in   (rstn_in),
      .async_in  ({fp_remote_loop_in, fp_local_loop_in, line_link_up_in,
                   line_err_evt_in}),
      .sync_out  (pin_s)
   );

   assign evt_s     = pin_s[8:0];
   assign link_up_s = pin_s[9];
   assign fp_lal_s  = pin_s[10];
   assign fp_rdl_s  = pin_s[11];
   assign evt_pulse = evt_s & ~evt_prev_q;

   // APB decode, shared by the read mux and the write path
   function automatic logic [4:0] reg_index(input logic [11:0] a);
      logic [11:0] off;
      off = a - dlem_pkg::ADDR_ERR0;
      if (a == dlem_pkg::ADDR_CMD) begin
         reg_index = 5'h00;
      end else if (a == dlem_pkg::ADDR_CFG) begin
         reg_index = 5'h01;
      end else if (a == dlem_pkg::ADDR_EM_A) begin
         reg_index = 5'h02;
      end else if (a == dlem_pkg::ADDR_EM_B) begin
         reg_index = 5'h03;
      end else if (a == dlem_pkg::ADDR_EM_C) begin
         reg_index = 5'h04;
      end else if (a == dlem_pkg::ADDR_STAT) begin
         reg_index = 5'h05;
      end else if (a == dlem_pkg::ADDR_ACT) begin
         reg_index = 5'h06;
      end else if (a == dlem_pkg::ADDR_SAVED) begin
         reg_index = 5'h07;
      end else if (a >= dlem_pkg::ADDR_ERR0 && off[1:0] == 2'h0
                   && off[11:2] < 10'(dlem_pkg::ERR_NUM)) begin
         reg_index = 5'h10 + {1'b0, off[5:2]};
      end else begin
         reg_index = 5'h1F;
      end
   endfunction

   dlem_pkg::dlem_cfg_type cfg_q, cfg_d, act_q, act_d, sav_q, sav_d;
   dlem_pkg::dlem_em_type  em_q, em_d, ema_q, ema_d, emsav_q, emsav_d;
   logic        pready_d;
   logic        pslverr_d;
   logic [31:0] prdata_d;
   logic [4:0]  idx;
   logic        wr_acc;
   logic        cmd_start;
   logic        cmd_clear;
   dlem_pkg::dlem_mon_type mon_q, mon_d;
   logic [15:0] secs_q, secs_d, ierr_q, ierr_d, ei_q, ei_d;
   logic [15:0] insp_q, insp_d;
   logic [16:0] ierr_sum;
   logic [1:0]  new_err;
   logic        mon_restart;
   logic        restart;

   always_comb begin
      idx       = reg_index(paddr_in);
      wr_acc    = psel_in & penable_in & pready_out & pwrite_in;
      pready_d  = psel_in & penable_in & ~pready_out;
      pslverr_d = 1'b0;
      prdata_d  = prdata_out;
      cfg_d     = cfg_q;
      em_d      = em_q;
      sav_d     = sav_q;
      emsav_d   = emsav_q;
      cmd_start = 1'b0;
      cmd_clear = 1'b0;
      if (pready_d) begin
         pslverr_d = (idx == 5'h1F);
         prdata_d  = 32'h0000_0000;
         if (idx == 5'h01) begin
            prdata_d = 32'(cfg_q);
         end else if (idx == 5'h02) begin
            prdata_d = {em_q.inttime, em_q.maxint};
         end else if (idx == 5'h03) begin
            prdata_d = {em_q.totint, em_q.intcnt};
         end else if (idx == 5'h04) begin
            prdata_d = {16'h0000, em_q.startdelay};
         end else if (idx == 5'h05) begin
            prdata_d = {insp_q, ei_q[7:0], 3'h0, link_up_s, mon_q};
         end else if (idx == 5'h06) begin
            prdata_d = 32'(act_q);
         end else if (idx == 5'h07) begin
            prdata_d = 32'(sav_q);
         end else if (idx[4]) begin
            prdata_d = {16'h0000, err_cnt[idx[3:0]]};
         end
      end
      if (wr_acc) begin
         if (idx == 5'h00) begin
            cmd_start = pwdata_in[dlem_pkg::CMD_START];
            cmd_clear = pwdata_in[dlem_pkg::CMD_CLEAR];
            if (pwdata_in[dlem_pkg::CMD_SAVE]) begin
               sav_d   = cfg_q;
               emsav_d = em_q;
            end
            if (pwdata_in[dlem_pkg::CMD_RECALL]) begin
               cfg_d = sav_q;
               em_d  = emsav_q;
            end
         end else if (idx == 5'h01) begin
            cfg_d = pwdata_in[16:0];
            // out-of-range rates keep the previous count
            if (pwdata_in[6:0] < dlem_pkg::TS_MIN
                || pwdata_in[6:0] > dlem_pkg::TS_MAX) begin
               cfg_d.timeslots = cfg_q.timeslots;
            end
         end else if (idx == 5'h02) begin
            em_d.maxint  = pwdata_in[15:0];
            em_d.inttime = pwdata_in[31:16];
         end else if (idx == 5'h03) begin
            em_d.intcnt = pwdata_in[15:0];
            em_d.totint = pwdata_in[31:16];
         end else if (idx == 5'h04) begin
            em_d.startdelay = pwdata_in[15:0];
         end
      end
   end

   // one-second time base
   logic [24:0] tick_cnt_q, tick_cnt_d;
   logic        tick_q, tick_d;

   always_comb begin
      tick_d     = 1'b0;
      tick_cnt_d = tick_cnt_q + 25'h0000001;
      if (tick_cnt_q == 25'(SEC_CYCLES - 1)) begin
         tick_cnt_d = 25'h0000000;
         tick_d     = 1'b1;
      end
   end

   // error monitor
   always_comb begin
      new_err     = {1'b0, evt_pulse[dlem_pkg::ERR_CRC]}
                    + {1'b0, evt_pulse[dlem_pkg::ERR_SYNC_LOSS]};
      ierr_sum    = {1'b0, ierr_q} + {15'h0000, new_err};
      mon_d       = mon_q;
      secs_d      = secs_q;
      ierr_d      = ierr_sum[16] ? 16'hFFFF : ierr_sum[15:0];
      ei_d        = ei_q;
      insp_d      = insp_q;
      mon_restart = 1'b0;
      case (mon_q)
         dlem_pkg::MON_IDLE: begin
            secs_d = 16'h0000;
            ierr_d = 16'h0000;
            if (link_up_s && ema_q.maxint != 16'h0000) begin
               mon_d = (ema_q.startdelay == 16'h0000) ? dlem_pkg::MON_INT
                                                      : dlem_pkg::MON_DELAY;
            end
         end
         dlem_pkg::MON_DELAY: begin
            ierr_d = 16'h0000;
            if (tick_q) begin
               secs_d = secs_q + 16'h0001;
               if (secs_q + 16'h0001 >= ema_q.startdelay) begin
                  mon_d  = dlem_pkg::MON_INT;
                  secs_d = 16'h0000;
               end
            end
         end
         dlem_pkg::MON_INT: begin
            if (tick_q) begin
               secs_d = secs_q + 16'h0001;
               // an inttime of zero behaves as one second
               if (secs_q + 16'h0001 >= ema_q.inttime) begin
                  secs_d = 16'h0000;
                  ierr_d = {14'h0000, new_err};
                  insp_d = insp_q + 16'h0001;
                  if (ierr_sum >= {1'b0, ema_q.maxint}) begin
                     ei_d = ei_q + 16'h0001;
                     if (ei_q + 16'h0001 >= ema_q.intcnt) begin
                        mon_restart = 1'b1;
                     end
                  end
                  if (!mon_restart && ema_q.totint != 16'h0000
                      && insp_q + 16'h0001 >= ema_q.totint) begin
                     mon_d = dlem_pkg::MON_STOP;
                  end
               end
            end
         end
         dlem_pkg::MON_STOP: begin
            ierr_d = ierr_q;
         end
         default: begin
            mon_d = dlem_pkg::MON_IDLE;
         end
      endcase
      if (!link_up_s) begin
         mon_d = dlem_pkg::MON_IDLE;
      end
      restart = cmd_start | mon_restart;
      if (restart) begin
         mon_d  = dlem_pkg::MON_IDLE;
         secs_d = 16'h0000;
         ierr_d = 16'h0000;
         ei_d   = 16'h0000;
         insp_d = 16'h0000;
      end
      // pending settings take effect only here
      act_d = restart ? cfg_q : act_q;
      ema_d = restart ? em_q : ema_q;
   end

   // line-side outputs
   logic [1:0] loop_d;
   logic [1:0] ltx_sel_d;
   logic [1:0] ser_sel_d;

   always_comb begin
      loop_d = cfg_q.loopback;
      if (cfg_q.loopback == dlem_pkg::LOOP_OFF && cfg_q.fpsw_en) begin
         if (fp_lal_s) begin
            loop_d = dlem_pkg::LOCAL_ANALOG_LOOP;
         end else if (fp_rdl_s) begin
            loop_d = dlem_pkg::REMOTE_DIGITAL_LOOP;
         end
      end
      case (act_d.clk_mode)
         dlem_pkg::CLK_EXTERNAL: begin
            ltx_sel_d = dlem_pkg::CLKSRC_SER_TX;
            ser_sel_d = dlem_pkg::CLKSRC_SER_TX;
         end
         dlem_pkg::CLK_RECOVER: begin
            ltx_sel_d = dlem_pkg::CLKSRC_LINE_RX;
            ser_sel_d = dlem_pkg::CLKSRC_LINE_RX;
         end
         default: begin
            ltx_sel_d = dlem_pkg::CLKSRC_OSC;
            ser_sel_d = dlem_pkg::CLKSRC_OSC;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         pready_out          <= 1'b0;
         pslverr_out         <= 1'b0;
         prdata_out          <= 32'h0000_0000;
         cfg_q               <= dlem_pkg::CFG_RST;
         act_q               <= dlem_pkg::CFG_RST;
         sav_q               <= dlem_pkg::CFG_RST;
         em_q                <= dlem_pkg::EM_RST;
         ema_q               <= dlem_pkg::EM_RST;
         emsav_q             <= dlem_pkg::EM_RST;
         tick_cnt_q          <= 25'h0000000;
         tick_q              <= 1'b0;
         evt_prev_q          <= 9'h000;
         mon_q               <= dlem_pkg::MON_IDLE;
         secs_q              <= 16'h0000;
         ierr_q              <= 16'h0000;
         ei_q                <= 16'h0000;
         insp_q              <= 16'h0000;
         line_enable_out     <= 1'b0;
         line_restart_out    <= 1'b0;
         rate_ts_out         <= dlem_pkg::TS_MIN;
         rate_kbps_out       <= dlem_pkg::KBPS_PER_TS;
         line_tx_clk_sel_out <= 2'h0;
         ser_clk_sel_out     <= 2'h0;
         annex_b_out         <= 1'b0;
         line_probe_out      <= 1'b0;
         loopback_out        <= 2'h0;
         prbs_out            <= 2'h0;
      end else begin
         pready_out          <= pready_d;
         pslverr_out         <= pslverr_d;
         prdata_out          <= prdata_d;
         cfg_q               <= cfg_d;
         act_q               <= act_d;
         sav_q               <= sav_d;
         em_q                <= em_d;
         ema_q               <= ema_d;
         emsav_q             <= emsav_d;
         tick_cnt_q          <= tick_cnt_d;
         tick_q              <= tick_d;
         evt_prev_q          <= evt_s;
         mon_q               <= mon_d;
         secs_q              <= secs_d;
         ierr_q              <= ierr_d;
         ei_q                <= ei_d;
         insp_q              <= insp_d;
         // port enable is immediate; the restart pulse drops it for a cycle
         line_enable_out     <= cfg_q.link_en & ~restart;
         line_restart_out    <= restart;
         rate_ts_out         <= act_d.timeslots;
         rate_kbps_out       <= 13'(act_d.timeslots) * dlem_pkg::KBPS_PER_TS;
         line_tx_clk_sel_out <= ltx_sel_d;
         ser_clk_sel_out     <= ser_sel_d;
         annex_b_out         <= act_d.annex_b;
         line_probe_out      <= act_d.line_probe;
         loopback_out        <= loop_d;
         prbs_out            <= cfg_q.pattern;
      end
   end

   // one saturating counter per line error kind
   genvar gi;
   generate
      for (gi = 0; gi < dlem_pkg::ERR_NUM; gi++) begin : g_err
         dlem_err_counter u_cnt (
            .ref_clk_in(ref_clk_in),
            .rstn_in   (rstn_in),
            .inc_in    (evt_pulse[gi]),
            .clr_in    (cmd_clear),
            .count_out (err_cnt[gi])
         );
      end
   endgenerate
endmodule

// ===== dlem_pkg.sv
/*
 dlem_pkg: constants, register map and carrier types of the line error
 monitor. Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package dlem_pkg;

   localparam int CLK_HZ     = 20_000_000;
   localparam int TICK_S     = 1;
   localparam int SEC_CYCLES = TICK_S * CLK_HZ;

   localparam logic [11:0] ADDR_CMD   = 12'h000;
   localparam logic [11:0] ADDR_CFG   = 12'h004;
   localparam logic [11:0] ADDR_EM_A  = 12'h008;
   localparam logic [11:0] ADDR_EM_B  = 12'h00C;
   localparam logic [11:0] ADDR_EM_C  = 12'h010;
   localparam logic [11:0] ADDR_STAT  = 12'h014;
   localparam logic [11:0] ADDR_ACT   = 12'h018;
   localparam logic [11:0] ADDR_SAVED = 12'h01C;
   localparam logic [11:0] ADDR_ERR0  = 12'h020;

   localparam int CMD_START  = 0;
   localparam int CMD_CLEAR  = 1;
   localparam int CMD_SAVE   = 2;
   localparam int CMD_RECALL = 3;

   localparam int ERR_NUM       = 9;
   localparam int ERR_CRC       = 0;
   localparam int ERR_SYNC_LOSS = 1;

   localparam logic [6:0]  TS_MIN      = 7'h01;
   localparam logic [6:0]  TS_MAX      = 7'h48;
   localparam logic [12:0] KBPS_PER_TS = 13'h040;

   localparam logic [1:0] CLKSRC_OSC     = 2'h0;
   localparam logic [1:0] CLKSRC_SER_TX  = 2'h1;
   localparam logic [1:0] CLKSRC_LINE_RX = 2'h2;

   typedef enum logic [1:0] {
      CLK_INTERNAL = 2'h0,
      CLK_EXTERNAL = 2'h1,
      CLK_RECOVER  = 2'h2
   } dlem_clk_type;

   typedef enum logic [1:0] {
      LOOP_OFF            = 2'h0,
      LOCAL_ANALOG_LOOP   = 2'h1,
      REMOTE_DIGITAL_LOOP = 2'h2
   } dlem_loop_type;

   typedef enum logic [1:0] {
      PRBS_OFF         = 2'h0,
      PRBS_511         = 2'h1,
      PRBS_WITH_ERRORS = 2'h2
   } dlem_prbs_type;

   typedef enum logic [3:0] {
      MON_IDLE  = 4'h1,
      MON_DELAY = 4'h2,
      MON_INT   = 4'h4,
      MON_STOP  = 4'h8
   } dlem_mon_type;

   typedef struct packed {
      logic          fpsw_en;
      dlem_loop_type loopback;
      dlem_prbs_type pattern;
      logic          link_en;
      logic          line_probe;
      logic          annex_b;
      dlem_clk_type  clk_mode;
      logic [6:0]    timeslots;
   } dlem_cfg_type;

   typedef struct packed {
      logic [15:0] maxint;
      logic [15:0] inttime;
      logic [15:0] intcnt;
      logic [15:0] totint;
      logic [15:0] startdelay;
   } dlem_em_type;

   localparam dlem_cfg_type CFG_RST = '{1'b0, LOOP_OFF, PRBS_OFF, 1'b1,
      1'b0, 1'b0, CLK_INTERNAL, 7'h01};
   localparam dlem_em_type EM_RST = '{16'h0000, 16'h0001, 16'h0001,
      16'h0000, 16'h0000};

endpackage

// ===== dlem_sync2.sv
/*
 dlem_sync2: two-flop synchroniser for a vector of pin levels.
 Assumes each bit is an independent slow level from outside the clock.
*/
`timescale 1ns/1ps
module dlem_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rstn_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ===== dlem_err_counter.sv
/*
 dlem_err_counter: 16-bit saturating event counter with clear.
 Assumes inc_in is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module dlem_err_counter (
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        inc_in,
   input  wire logic        clr_in,
   output logic      [15:0] count_out
);
   logic [15:0] cnt_d;

   always_comb begin
      cnt_d = count_out;
      if (clr_in) begin
         cnt_d = 16'h0000;
      end
      if (inc_in && cnt_d != 16'hFFFF) begin
         cnt_d = cnt_d + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         count_out <= 16'h0000;
      end else begin
         count_out <= cnt_d;
      end
   end
endmodule

// ===== dlem_checker.sv
/* dlem_checker: port assertions for dlem_top.
   assumes it is bound into dlem_top with SEC_CYCLES handed on. */
`timescale 1ns/1ps
module dlem_checker #(
   parameter int SEC_CYCLES = 20
) (
   input wire logic        ref_clk_in,
   input wire logic        rstn_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic        pready_out,
   input wire logic        line_enable_out,
   input wire logic        line_restart_out,
   input wire logic [6:0]  rate_ts_out,
   input wire logic [12:0] rate_kbps_out,
   input wire logic [1:0]  line_tx_clk_sel_out,
   input wire logic [1:0]  ser_clk_sel_out,
   input wire logic        annex_b_out,
   input wire logic        line_probe_out,
   input wire logic [1:0]  loopback_out,
   input wire logic [1:0]  prbs_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // a write completes only at the edge that sees pready
   sequence wr_done(logic [11:0] a);
      psel_in && penable_in && pready_out && pwrite_in && paddr_in == a;
   endsequence
   rate_calc_a: assert property (
      rate_kbps_out == {rate_ts_out, 6'h00}) else $error("rate not ts*64");
   ts_range_a: assert property (
      rate_ts_out >= 7'h01 && rate_ts_out <= 7'h48) else $error("ts range");
   clk_pair_a: assert property (
      line_tx_clk_sel_out == ser_clk_sel_out && ser_clk_sel_out != 2'h3)
      else $error("clock selects");
   test_modes_a: assert property (
      loopback_out != 2'h3 && prbs_out != 2'h3) else $error("test mode");
   hold_pending_a: assert property (
      $changed({rate_ts_out, line_tx_clk_sel_out, annex_b_out,
      line_probe_out}) |-> line_restart_out) else $error("early apply");
   start_restart_a: assert property (
      wr_done(12'h000) ##0 pwdata_in[0] |-> ##[1:2] line_restart_out)
      else $error("start gave no restart");
   restart_pulse_a: assert property (
      line_restart_out |=> !line_restart_out) else $error("restart width");
   port_off_a: assert property (
      wr_done(12'h004) ##0 !pwdata_in[11] |-> ##3 !line_enable_out [*2])
      else $error("port still enabled");
endmodule

// ===== dlem_line_model.sv
/* dlem_line_model: far modem; trains while the port is enabled, drops
   on restart, sends error events on request. assumes the bench clock. */
`timescale 1ns/1ps
module dlem_line_model (
   input  wire logic       ref_clk_in,
   input  wire logic       line_enable_in,
   input  wire logic       line_restart_in,
   input  wire logic       err_run_in,
   output logic            line_link_up_out,
   output logic      [8:0] line_err_evt_out
);
   int         train_q = 0;
   logic [1:0] ph_q = 2'h0;
   initial line_link_up_out = 1'b0;
   initial line_err_evt_out = 9'h000;
   // no training while disabled; a restart drops the link at once
   always @(posedge ref_clk_in) begin
      train_q <= (!line_enable_in || line_restart_in) ? 0 : train_q + 1;
      line_link_up_out <= line_enable_in && !line_restart_in && train_q > 8;
      ph_q <= ph_q + 2'h1;
      // two high, two low, so every edge survives the synchroniser
      line_err_evt_out <= {9{err_run_in && line_link_up_out && ph_q[1]}};
   end
endmodule

// ===== tb_top.sv
/* tb_top: bench for dlem_top with the far modem model.
   assumes dlem_pkg compiled first; one second shortened to 20 cycles. */
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic [31:0] cfg; logic [6:0] ts;} dlem_row_type;
   logic        ref_clk_in, rstn_in, psel_in, penable_in, pwrite_in, serr;
   logic        pready_out, pslverr_out, line_link_up_in, line_enable_out;
   logic        fp_local_loop_in, fp_remote_loop_in, line_restart_out;
   logic        annex_b_out, line_probe_out, err_run;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic [8:0]  line_err_evt_in;
   logic [6:0]  rate_ts_out, ts_prev;
   logic [12:0] rate_kbps_out;
   logic [1:0]  line_tx_clk_sel_out, ser_clk_sel_out, loopback_out, prbs_out;
   int          error_cnt, comparisons, n_evt, res, i;
   // ts 73 and 0 are refused, so the timeslot field keeps 72
   dlem_row_type rows [4] = '{'{32'h5AC8, 7'h48}, '{32'hAF49, 7'h48},
      '{32'h0800, 7'h48}, '{32'h0801, 7'h01}};
   dlem_top #(.SEC_CYCLES(20)) uut (.ref_clk_in, .rstn_in, .psel_in,
      .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
      .pready_out, .pslverr_out, .line_link_up_in, .line_err_evt_in,
      .fp_local_loop_in, .fp_remote_loop_in, .line_enable_out,
      .line_restart_out, .rate_ts_out, .rate_kbps_out,
      .line_tx_clk_sel_out, .ser_clk_sel_out, .annex_b_out,
      .line_probe_out, .loopback_out, .prbs_out);
   dlem_line_model u_line (.ref_clk_in, .line_enable_in(line_enable_out),
      .line_restart_in(line_restart_out), .err_run_in(err_run),
      .line_link_up_out(line_link_up_in), .line_err_evt_out(line_err_evt_in));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      cyc(1);
      penable_in <= 1'b1;
      do begin
         cyc(1);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready", 32'h0, 32'h1);
         report_and_stop();
      end
      rd = prdata_out;
      serr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      cyc(1);
   endtask
   // cycles until the next restart pulse, n if none comes
   task automatic watch(input int n);
      for (res = 0; res < n && line_restart_out !== 1'b1; res++) cyc(1);
   endtask
   always @(posedge line_err_evt_in[0]) n_evt++;
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      {rstn_in, psel_in, penable_in, pwrite_in, err_run} = 5'h00;
      {fp_local_loop_in, fp_remote_loop_in, paddr_in, pwdata_in} = '0;
      {error_cnt, comparisons, n_evt} = '0;
      ts_prev = 7'h01;
      cyc(4);
      rstn_in <= 1'b1;
      cyc(1);
      chk("reset kbps", rate_kbps_out, 32'h40);
      apb(1'b0, 12'h004, 32'h0);
      chk("cfg reset", rd, 32'h801);
      apb(1'b0, 12'h00C, 32'h0);
      chk("em reset", rd, 32'h1);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped err", serr, 32'h1);
      chk("unmapped data", rd, 32'h0);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, 12'h004, rows[i].cfg);
         chk("pending ts", rate_ts_out, ts_prev);
         apb(1'b1, 12'h000, 32'h1);
         cyc(2);
         chk("ts", rate_ts_out, rows[i].ts);
         chk("kbps", rate_kbps_out, rows[i].ts * 32'h40);
         chk("txc", line_tx_clk_sel_out, rows[i].cfg[8:7]);
         chk("serc", ser_clk_sel_out, rows[i].cfg[8:7]);
         chk("annex", {line_probe_out, annex_b_out}, rows[i].cfg[10:9]);
         chk("loop", {loopback_out, prbs_out}, rows[i].cfg[15:12]);
         ts_prev = rows[i].ts;
      end
      fp_local_loop_in <= 1'b1;
      cyc(8);
      chk("fp ignored", loopback_out, 32'h0);
      apb(1'b1, 12'h004, 32'h10801);
      cyc(8);
      chk("fp local", loopback_out, 32'h1);
      fp_local_loop_in <= 1'b0;
      fp_remote_loop_in <= 1'b1;
      cyc(8);
      chk("fp remote", loopback_out, 32'h2);
      fp_remote_loop_in <= 1'b0;
      apb(1'b1, 12'h000, 32'h4);
      apb(1'b1, 12'h004, 32'h801);
      apb(1'b1, 12'h000, 32'h8);
      apb(1'b0, 12'h004, 32'h0);
      chk("recall", rd, 32'h10801);
      apb(1'b1, 12'h004, 32'h10001);
      cyc(30);
      chk("port off", line_enable_out, 32'h0);
      apb(1'b1, 12'h004, 32'h801);
      // 2 errors per event, 10 per second: errored against 4
      apb(1'b1, 12'h008, 32'h10004);
      apb(1'b1, 12'h00C, 32'h2);
      apb(1'b1, 12'h010, 32'h1);
      apb(1'b1, 12'h000, 32'h1);
      err_run <= 1'b1;
      cyc(2);
      watch(400);
      chk("err restart", res >= 30 && res < 400, 32'h1);
      apb(1'b0, 12'h014, 32'h0);
      chk("counts", rd[31:8], 32'h0);
      apb(1'b1, 12'h008, 32'h10000);
      apb(1'b1, 12'h000, 32'h1);
      cyc(2);
      watch(200);
      chk("no restart", res, 32'hC8);
      apb(1'b1, 12'h008, 32'h10100);
      apb(1'b1, 12'h00C, 32'h20001);
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      cyc(150);
      apb(1'b0, 12'h014, 32'h0);
      chk("stopped", {rd[31:16], rd[3:0]}, 32'h28);
      err_run <= 1'b0;
      cyc(10);
      apb(1'b1, 12'h000, 32'h2);
      cyc(4);
      apb(1'b0, 12'h040, 32'h0);
      chk("cleared", rd, 32'h0);
      n_evt = 0;
      err_run <= 1'b1;
      cyc(30);
      err_run <= 1'b0;
      cyc(10);
      for (i = 0; i < 9; i++) begin
         apb(1'b0, 12'h020 + 12'(4 * i), 32'h0);
         chk("event count", rd, n_evt);
      end
      report_and_stop();
   end
endmodule

bind dlem_top dlem_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.ref_clk_in,
   .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
   .pready_out, .line_enable_out, .line_restart_out, .rate_ts_out,
   .rate_kbps_out, .line_tx_clk_sel_out, .ser_clk_sel_out, .annex_b_out,
   .line_probe_out, .loopback_out, .prbs_out);
